// >>> src/boundary_scan_test_port.sv
// boundary-scan test port with programming stream and its word buffer
// assumes every pin input is asynchronous to mclk; test clock much slower
`timescale 1ns/100ps
`include "bscan_map.svh"

module scan_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign inReady  = (count != CW'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= AW'(wrPtr + 1'b1);
            end
            if (pop) begin
                rdPtr <= AW'(rdPtr + 1'b1);
            end
            if (push && !pop) begin
                count <= CW'(count + 1'b1);
            end else if (pop && !push) begin
                count <= CW'(count - 1'b1);
            end
        end
    end
endmodule : scan_word_fifo

module boundary_scan_test_port
    import bscan_pkg::*;
#(
    parameter int                NUM_IO  = 96,
    parameter int                NUM_IN  = 4,
    parameter int                NUM_MC  = 8,
    parameter int                FIFO_DEPTH = 16,
    // arbitrary identification value, lsb set as the standard demands
    parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h0a5c_0001
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  jtagEnable,
    input  wire logic [3:0]            pinIn,
    output logic [3:0]                 pinOut,
    output logic [3:0]                 pinOeN,
    input  wire logic [3:0]            userOut,
    input  wire logic [3:0]            userOeN,
    output logic [3:0]                 userIn,
    input  wire logic [NUM_IO-1:0]     ioIn,
    output logic [NUM_IO-1:0]          ioOut,
    output logic [NUM_IO-1:0]          ioOeN,
    input  wire logic [NUM_IO-1:0]     coreOut,
    input  wire logic [NUM_IO-1:0]     coreOeN,
    output logic [NUM_IO-1:0]          coreIoIn,
    input  wire logic [NUM_IN-1:0]     inPin,
    output logic [NUM_IN-1:0]          coreInPin,
    input  wire logic [NUM_MC-1:0]     mcValue,
    output logic [NUM_MC-1:0]          mcTest,
    output logic                       progValid,
    input  wire logic                  progReady,
    output logic [`ISP_WIDTH-1:0]      progData
);
    localparam int IO_BASE = NUM_MC + NUM_IN;
    localparam int CHAIN   = IO_BASE + 3 * NUM_IO;

    logic [3:0]             pinS1;
    logic [3:0]             pinS2;
    logic [NUM_IO-1:0]      ioS1;
    logic [NUM_IO-1:0]      ioS2;
    logic [NUM_IN-1:0]      inS1;
    logic [NUM_IN-1:0]      inS2;
    logic                   enS1;
    logic                   jtagOn;
    logic                   tckPrev;
    logic                   tckRise;
    logic                   tckFall;
    logic                   tmsS;
    logic                   tdiS;
    tap_state_t             tapState;
    tap_state_t             next_tapState;
    logic [`IR_WIDTH-1:0]   irShift;
    logic [`IR_WIDTH-1:0]   irActive;
    dr_sel_t                drSel;
    logic                   bypassBit;
    logic [`ID_WIDTH-1:0]   idShift;
    logic [CHAIN-1:0]       bsr;
    logic [CHAIN-1:0]       capVec;
    logic [`ISP_WIDTH-1:0]  ispShift;
    logic [NUM_IO-1:0]      updOut;
    logic [NUM_IO-1:0]      updOeN;
    logic [NUM_MC-1:0]      updMc;
    logic                   extest;
    logic                   ispPush;
    logic                   fifoInReady;
    logic                   fifoOutValid;
    logic [`ISP_WIDTH-1:0]  fifoOutData;
    logic                   fifoPop;
    logic                   tdoBit;

    // synchronisers: first stage feeds only the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinS1 <= '0;
            pinS2 <= '0;
            ioS1  <= '0;
            ioS2  <= '0;
            inS1  <= '0;
            inS2  <= '0;
            enS1  <= 1'b0;
            jtagOn <= 1'b0;
            tckPrev <= 1'b0;
        end else begin
            pinS1 <= pinIn;
            pinS2 <= pinS1;
            ioS1  <= ioIn;
            ioS2  <= ioS1;
            inS1  <= inPin;
            inS2  <= inS1;
            enS1  <= jtagEnable;
            jtagOn <= enS1;
            tckPrev <= pinS2[`PIN_TCK];
        end
    end

    assign tckRise = jtagOn && pinS2[`PIN_TCK] && !tckPrev;
    assign tckFall = jtagOn && !pinS2[`PIN_TCK] && tckPrev;
    assign tmsS    = pinS2[`PIN_TMS];
    assign tdiS    = pinS2[`PIN_TDI];

    always_comb begin
        next_tapState = tapState;
        case (tapState)
            TLR:      next_tapState = tmsS ? TLR : RTI;
            RTI:      next_tapState = tmsS ? SEL_DR : RTI;
            SEL_DR:   next_tapState = tmsS ? SEL_IR : CAP_DR;
            CAP_DR:   next_tapState = tmsS ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_tapState = tmsS ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_tapState = tmsS ? UPD_DR : PAUSE_DR;
            PAUSE_DR: next_tapState = tmsS ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_tapState = tmsS ? UPD_DR : SHIFT_DR;
            UPD_DR:   next_tapState = tmsS ? SEL_DR : RTI;
            SEL_IR:   next_tapState = tmsS ? TLR : CAP_IR;
            CAP_IR:   next_tapState = tmsS ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_tapState = tmsS ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_tapState = tmsS ? UPD_IR : PAUSE_IR;
            PAUSE_IR: next_tapState = tmsS ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_tapState = tmsS ? UPD_IR : SHIFT_IR;
            UPD_IR:   next_tapState = tmsS ? SEL_DR : RTI;
            default:  next_tapState = TLR;
        endcase
    end

    // power-up and disabled port both park the controller in reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tapState <= TLR;
        end else if (!jtagOn) begin
            tapState <= TLR;
        end else if (tckRise) begin
            tapState <= next_tapState;
        end
    end

    // instruction register; unknown codes fall back to bypass
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irShift  <= `IR_CAPTURE;
            irActive <= `IR_IDCODE;
        end else if (tapState == TLR) begin
            irActive <= `IR_IDCODE;
        end else if (tckRise) begin
            case (tapState)
                CAP_IR:   irShift <= `IR_CAPTURE;
                SHIFT_IR: irShift <= {tdiS, irShift[`IR_WIDTH-1:1]};
                UPD_IR:   irActive <= irShift;
                default:  irShift <= irShift;
            endcase
        end
    end

    always_comb begin
        if (irActive == `IR_EXTEST || irActive == `IR_SAMPLE) begin
            drSel = DR_BOUNDARY;
        end else if (irActive == `IR_IDCODE) begin
            drSel = DR_IDCODE;
        end else if (irActive == `IR_ISP) begin
            drSel = DR_ISP;
        end else begin
            drSel = DR_BYPASS;
        end
    end

    assign extest = (irActive == `IR_EXTEST);

    // capture vector: macrocell cells nearest the data-out end, then inputs, then I/O
    genvar g;
    generate
        for (g = 0; g < NUM_MC; g++) begin : g_mc_cell
            assign capVec[g] = mcValue[g];
        end
        for (g = 0; g < NUM_IN; g++) begin : g_in_cell
            assign capVec[NUM_MC + g] = inS2[g];
        end
        for (g = 0; g < NUM_IO; g++) begin : g_io_cell
            assign capVec[IO_BASE + 3*g]     = ioS2[g];
            assign capVec[IO_BASE + 3*g + 1] = coreOut[g];
            assign capVec[IO_BASE + 3*g + 2] = coreOeN[g];
        end
    endgenerate

    // data registers: bypass, identification, boundary chain, programming word
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bypassBit <= 1'b0;
            idShift   <= '0;
            bsr       <= '0;
            ispShift  <= '0;
        end else if (tckRise && tapState == CAP_DR) begin
            bypassBit <= 1'b0;
            idShift   <= ID_CODE;
            if (drSel == DR_BOUNDARY) begin
                bsr <= capVec;
            end
            // tester polls the lsb: one means the word buffer is full
            ispShift <= {{(`ISP_WIDTH-1){1'b0}}, !fifoInReady};
        end else if (tckRise && tapState == SHIFT_DR) begin
            case (drSel)
                DR_BYPASS:   bypassBit <= tdiS;
                DR_IDCODE:   idShift <= {tdiS, idShift[`ID_WIDTH-1:1]};
                DR_BOUNDARY: bsr <= {tdiS, bsr[CHAIN-1:1]};
                default:     ispShift <= {tdiS, ispShift[`ISP_WIDTH-1:1]};
            endcase
        end
    end

    // update stages, loaded by both preload and external test
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            updOut <= '0;
            updOeN <= '1;
            updMc  <= '0;
        end else if (tckRise && tapState == UPD_DR && drSel == DR_BOUNDARY) begin
            for (int i = 0; i < NUM_IO; i++) begin
                updOut[i] <= bsr[IO_BASE + 3*i + 1];
                updOeN[i] <= bsr[IO_BASE + 3*i + 2];
            end
            updMc <= bsr[NUM_MC-1:0];
        end
    end

    // a word arriving while the buffer is full is dropped; the status bit warns first
    assign ispPush = tckRise && tapState == UPD_DR && drSel == DR_ISP;

    scan_word_fifo #(
        .WIDTH (`ISP_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) scan_word_fifo_inst (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .inValid  (ispPush),
        .inReady  (fifoInReady),
        .inData   (ispShift),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOutData)
    );

    assign fifoPop = !progValid || progReady;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            progValid <= 1'b0;
            progData  <= '0;
        end else if (fifoPop) begin
            progValid <= fifoOutValid;
            progData  <= fifoOutData;
        end
    end

    always_comb begin
        if (tapState == SHIFT_IR) begin
            tdoBit = irShift[0];
        end else begin
            case (drSel)
                DR_BYPASS:   tdoBit = bypassBit;
                DR_IDCODE:   tdoBit = idShift[0];
                DR_BOUNDARY: tdoBit = bsr[0];
                default:     tdoBit = ispShift[0];
            endcase
        end
    end

    // test pins: data-out changes on the falling test clock edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut <= `PIN_OUT_RESET;
            pinOeN <= `PIN_OEN_RESET;
            userIn <= '0;
        end else if (!jtagOn) begin
            pinOut <= userOut;
            pinOeN <= userOeN;
            userIn <= pinS2;
        end else begin
            pinOut[2:0] <= '0;
            pinOeN[2:0] <= '1;
            userIn      <= '0;
            if (tckFall) begin
                pinOut[`PIN_TDO] <= tdoBit;
                pinOeN[`PIN_TDO] <= !(tapState == SHIFT_DR || tapState == SHIFT_IR);
            end else if (tapState == TLR) begin
                // a freshly enabled port must not keep the user's drive on data-out
                pinOeN[`PIN_TDO] <= 1'b1;
            end
        end
    end

    // pins and core: the update stages take the pads only under external test
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ioOut     <= '0;
            ioOeN     <= '1;
            coreIoIn  <= '0;
            coreInPin <= '0;
            mcTest    <= '0;
        end else begin
            ioOut     <= extest ? updOut : coreOut;
            ioOeN     <= extest ? updOeN : coreOeN;
            coreIoIn  <= ioS2;
            coreInPin <= inS2;
            mcTest    <= updMc;
        end
    end

    chk_tap_reset_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (tapState == TLR && tckRise && tmsS) |=> tapState == TLR)
        else $error("controller left reset with mode-select high");

    chk_state_only_on_edge: assert property (@(posedge mclk) disable iff (!arst_n)
        (!tckRise && jtagOn) |=> ($stable(tapState) || !jtagOn))
        else $error("controller moved without a test clock rise");

    chk_idcode_after_reset: assert property (@(posedge mclk) disable iff (!arst_n)
        (tapState == TLR) |=> irActive == `IR_IDCODE)
        else $error("identification not selected after reset");

    chk_bypass_capture: assert property (@(posedge mclk) disable iff (!arst_n)
        (tckRise && tapState == CAP_DR) |=> !bypassBit && idShift == ID_CODE)
        else $error("bypass or identification capture wrong");

    chk_chain_shift: assert property (@(posedge mclk) disable iff (!arst_n)
        (tckRise && tapState == SHIFT_DR && drSel == DR_BOUNDARY)
        |=> bsr == {$past(tdiS), $past(bsr[CHAIN-1:1])})
        else $error("boundary chain did not shift by one");

    chk_chain_capture: assert property (@(posedge mclk) disable iff (!arst_n)
        (tckRise && tapState == CAP_DR && drSel == DR_BOUNDARY) |=> bsr == $past(capVec))
        else $error("boundary chain missed its capture");

    chk_extest_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        extest |=> ioOut == $past(updOut) && ioOeN == $past(updOeN))
        else $error("pads not driven from update stages");

    chk_tdo_enable: assert property (@(posedge mclk) disable iff (!arst_n)
        (tckFall && tapState == SHIFT_DR) |=> !pinOeN[`PIN_TDO] ##1 1'b1)
        else $error("data-out not driven during shift");

    chk_user_pins: assert property (@(posedge mclk) disable iff (!arst_n)
        (!jtagOn) |=> pinOut == $past(userOut) && pinOeN == $past(userOeN))
        else $error("test pins not handed to user logic");

    chk_isp_push: assert property (@(posedge mclk) disable iff (!arst_n)
        (ispPush && fifoInReady && !fifoPop) |=> scan_word_fifo_inst.count == $past(scan_word_fifo_inst.count) + 1'b1)
        else $error("programming word not buffered");

endmodule : boundary_scan_test_port

// >>> include/bscan_map.svh
// offsets, codes and pin positions of the boundary-scan test port
// assumes a single mclk domain; included by the test port and its bench
`ifndef BSCAN_MAP_SVH
`define BSCAN_MAP_SVH

// position of each test pin in the four-pin group
`define PIN_TDI 0
`define PIN_TMS 1
`define PIN_TCK 2
`define PIN_TDO 3

// instruction register
`define IR_WIDTH   4
`define IR_EXTEST  4'h0
`define IR_SAMPLE  4'h1
`define IR_IDCODE  4'h2
`define IR_ISP     4'h8
`define IR_BYPASS  4'hf
`define IR_CAPTURE 4'h1

// programming and identification data registers
`define ISP_WIDTH 8
`define ID_WIDTH  32

// reset values of the pin drivers: released, low
`define PIN_OEN_RESET 4'hf
`define PIN_OUT_RESET 4'h0

`endif

// >>> include/bscan_pkg.sv
// types shared by the boundary-scan test port
// assumes nothing beyond a SystemVerilog compiler
package bscan_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        DR_BYPASS, DR_IDCODE, DR_BOUNDARY, DR_ISP
    } dr_sel_t;

endpackage : bscan_pkg

// >>> test/scan_tester_model.sv
// tester model: drives data-in, mode-select and test clock, reads data-out
// assumes the device clock mclk; every pin change lands on its falling edge
`timescale 1ns/100ps

module scan_tester_model (
    input  wire logic       mclk,
    input  wire logic [3:0] pinOut,
    input  wire logic [3:0] pinOeN,
    output logic [3:0]      pinIn
);
    logic [2:0] drive;

    initial drive = 3'h0;

    // device wins where it drives; the data-out line has a pull-up
    always_comb begin
        for (int k = 0; k < 3; k++) pinIn[k] = !pinOeN[k] ? pinOut[k] : drive[k];
        pinIn[3] = !pinOeN[3] ? pinOut[3] : 1'b1;
    end

    // one period of 8 mclk: 3 high, 5 low; data-out read just before the rise
    task automatic tclk(input logic tms, input logic tdi, output logic tdo);
        @(negedge mclk);
        tdo = pinIn[3];
        drive[1] = tms;
        drive[0] = tdi;
        drive[2] = 1'b1;
        repeat (3) @(negedge mclk);
        drive[2] = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : tclk

    // no reset pin, so the state sequence itself brings the controller home
    task automatic tap_reset();
        logic t;
        repeat (5) tclk(1'b1, 1'b0, t);
        tclk(1'b0, 1'b0, t);
    endtask : tap_reset

    // from run-test-idle through one instruction or data scan and back, lsb first
    task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic t;
        dout = '0;
        tclk(1'b1, 1'b0, t);
        if (ir) tclk(1'b1, 1'b0, t);
        tclk(1'b0, 1'b0, t);
        tclk(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tclk(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tclk(1'b1, 1'b0, t);
        tclk(1'b0, 1'b0, t);
    endtask : scan
endmodule : scan_tester_model

// >>> test/boundary_scan_test_port_tb.sv
// self-checking bench of the boundary-scan test port, four I/O cells
// assumes the tester model drives the test pins; other inputs driven here
`timescale 1ns/100ps
`include "bscan_map.svh"

module boundary_scan_test_port_tb;
    localparam int NIO = 4;
    localparam int NMC = 8;
    localparam int LEN = 3 * NIO + 4 + NMC;
    localparam logic [31:0] ID = 32'h1357_2469; // arbitrary value, lsb set

    logic mclk, arst_n, jtagEnable, progValid, progReady;
    logic [3:0] pinIn, pinOut, pinOeN, userOut, userOeN, userIn, inPin, coreInPin;
    logic [NIO-1:0] ioIn, ioOut, ioOeN, coreOut, coreOeN, coreIoIn;
    logic [NMC-1:0] mcValue, mcTest;
    logic [`ISP_WIDTH-1:0] progData;
    logic [15:0] seed;
    int n_errors, checks;

    boundary_scan_test_port #(.NUM_IO(NIO), .NUM_MC(NMC), .ID_CODE(ID)) boundary_scan_test_port_inst (
        .mclk(mclk), .arst_n(arst_n), .jtagEnable(jtagEnable), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .userOut(userOut), .userOeN(userOeN), .userIn(userIn), .ioIn(ioIn),
        .ioOut(ioOut), .ioOeN(ioOeN), .coreOut(coreOut), .coreOeN(coreOeN), .coreIoIn(coreIoIn),
        .inPin(inPin), .coreInPin(coreInPin), .mcValue(mcValue), .mcTest(mcTest),
        .progValid(progValid), .progReady(progReady), .progData(progData)
    );

    scan_tester_model scan_tester_model_inst (.mclk(mclk), .pinOut(pinOut), .pinOeN(pinOeN), .pinIn(pinIn));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input bit ok, input string m);
        checks++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask : chk

    // new random pin and core values, applied at the falling edge
    task automatic shake();
        @(negedge mclk);
        seed = lfsr(seed);
        {userOut, userOeN, coreOut, coreOeN} = seed;
        seed = lfsr(seed);
        {ioIn, inPin, mcValue} = seed;
        repeat (6) @(negedge mclk);
    endtask : shake

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // a full run needs well under 1 ms of test clocks
    initial begin
        #2000000;
        n_errors++;
        report_and_stop();
    end

    initial begin : main
        logic [63:0] got, pre;
        logic [3:0] code;
        logic [7:0] q[$];
        logic t;
        n_errors = 0;
        checks = 0;
        seed = 16'h0046;
        arst_n = 1'b0;
        jtagEnable = 1'b0;
        progReady = 1'b0;
        {userOut, userOeN, coreOut, coreOeN, ioIn, inPin, mcValue} = '0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        // port disabled: pins and pads belong to the user logic
        repeat (4) begin
            shake();
            chk(pinOut === userOut && pinOeN === userOeN, "pins not user driven");
            chk(userIn === pinIn, "user pin input");
            chk(ioOut === coreOut && ioOeN === coreOeN && coreIoIn === ioIn && coreInPin === inPin, "pad path");
        end
        $display("test disabled done");
        jtagEnable = 1'b1;
        repeat (10) @(negedge mclk);
        // instruction after power-up reset is identification
        scan_tester_model_inst.tclk(1'b0, 1'b0, t);
        chk(pinOeN[3] === 1'b1, "data-out driven in idle");
        scan_tester_model_inst.scan(1'b0, 32, 64'h0, got);
        chk(got[31:0] === ID, "id after reset");
        scan_tester_model_inst.tap_reset();
        // identification and bypass, plus one unknown code that must act as bypass
        for (int k = 0; k < 3; k++) begin
            code = (k == 0) ? `IR_IDCODE : (k == 1) ? `IR_BYPASS : 4'h5;
            scan_tester_model_inst.scan(1'b1, 4, {60'h0, code}, got);
            chk(got[3:0] === `IR_CAPTURE, "instruction capture");
            seed = lfsr(seed);
            pre = {48'h0, seed};
            scan_tester_model_inst.scan(1'b0, (k == 0) ? 32 : 16, pre, got);
            if (k == 0) chk(got[31:0] === ID, "id read");
            else chk(got[15:0] === {pre[14:0], 1'b0}, "bypass delay");
        end
        $display("test instructions done");
        // sample/preload: live pins captured, preload enters the update stages
        shake();
        scan_tester_model_inst.scan(1'b1, 4, {60'h0, `IR_SAMPLE}, got);
        chk(got[3:0] === `IR_CAPTURE, "instruction capture");
        seed = lfsr(seed);
        pre = {40'h0, seed, seed[7:0] ^ 8'h5a};
        scan_tester_model_inst.scan(1'b0, LEN, pre, got);
        chk(got[NMC-1:0] === mcValue, "macrocell capture");
        chk(got[NMC+3:NMC] === inPin, "input cell capture");
        for (int i = 0; i < NIO; i++) chk(got[12 + 3 * i] === ioIn[i], "io cell capture");
        repeat (4) @(negedge mclk);
        chk(mcTest === pre[NMC-1:0], "macrocell update");
        chk(ioOut === coreOut && ioOeN === coreOeN, "sample drove pads");
        $display("test sample done");
        // extest: update stages drive the pads, core values ignored
        scan_tester_model_inst.scan(1'b1, 4, {60'h0, `IR_EXTEST}, got);
        repeat (2) begin
            shake();
            for (int i = 0; i < NIO; i++) begin
                chk(ioOut[i] === pre[13 + 3 * i] && ioOeN[i] === pre[14 + 3 * i], "extest drive");
            end
            seed = lfsr(seed);
            pre = {40'h0, seed, seed[15:8]};
            scan_tester_model_inst.scan(1'b0, LEN, pre, got);
            chk(got[NMC+3:NMC] === inPin, "chain in extest");
            repeat (4) @(negedge mclk);
        end
        $display("test extest done");
        // programming stream: fill while the consumer stalls, then drain
        scan_tester_model_inst.scan(1'b1, 4, {60'h0, `IR_ISP}, got);
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            scan_tester_model_inst.scan(1'b0, 8, {56'h0, seed[7:0]}, got);
            if (got[0] === 1'b1) break;
            q.push_back(seed[7:0]);
        end
        chk(q.size() >= 16, "buffer refused too early");
        chk(progValid === 1'b1 && progData === q[0], "stream head");
        repeat (300) begin
            @(negedge mclk);
            seed = lfsr(seed);
            progReady = seed[0];
            // the word taken at the coming rising edge stands from this falling edge on
            if (progValid === 1'b1 && progReady === 1'b1 && q.size() > 0) begin
                chk(progData === q[0], "stream order");
                void'(q.pop_front());
            end
        end
        @(negedge mclk);
        chk(q.size() == 0 && progValid === 1'b0, "stream not drained");
        scan_tester_model_inst.scan(1'b0, 8, 64'h0, got);
        chk(got[0] === 1'b0, "full flag after drain");
        $display("test programming done");
        report_and_stop();
    end
endmodule : boundary_scan_test_port_tb
